// ===== status_pkg.sv
// Purpose: shared constants and types for the status reporting register set
// Assumes: one clock, asynchronous active-low reset
// Notes:   bit weights are those of the status byte and event status register
package status_pkg;

   // ************************************************************
   // status byte bit positions
   // ************************************************************
   localparam int SB_FAULT   = 3;
   localparam int SB_MAV     = 4;
   localparam int SB_ESB     = 5;
   localparam int SB_MSS     = 6;
   localparam logic [7:0] SRE_MASK = 8'h38;

   // ************************************************************
   // event status bit positions
   // ************************************************************
   localparam int ES_OPC = 0;
   localparam int ES_QYE = 2;
   localparam int ES_EXE = 4;
   localparam int ES_CME = 5;
   localparam int ES_PON = 7;
   localparam logic [7:0] ES_USED = 8'hb5;

   // ************************************************************
   // property query codes and reset values
   // ************************************************************
   localparam logic [7:0] PROP_LQE   = 8'h04;
   localparam logic [7:0] PROP_FAULT = 8'h0f;
   localparam logic [7:0] PROP_LEE   = 8'h10;
   localparam logic [7:0] PROP_LCE   = 8'h20;
   localparam logic [7:0] RESET_BYTE = 8'h00;

   // ************************************************************
   // host command codes
   // ************************************************************
   typedef enum logic [3:0] {
      CMD_NONE    = 4'h0,
      CMD_STB_Q   = 4'h1,
      CMD_SRE     = 4'h2,
      CMD_SRE_Q   = 4'h3,
      CMD_ESR_Q   = 4'h4,
      CMD_ESE     = 4'h5,
      CMD_ESE_Q   = 4'h6,
      CMD_PSC     = 4'h7,
      CMD_PSC_Q   = 4'h8,
      CMD_CLS     = 4'h9,
      CMD_RST     = 4'ha,
      CMD_GET_Q   = 4'hb,
      CMD_OPC     = 4'hc,
      CMD_OPC_Q   = 4'hd,
      CMD_WAI     = 4'he
   } cmd_t;

   // one host request
   typedef struct packed {
      logic       valid;
      logic [1:0] intf;
      cmd_t       cmd;
      logic [7:0] arg;
   } host_req_t;

   // one error report from the command processor
   typedef struct packed {
      logic        query;
      logic        exec;
      logic        cmd;
      logic [1:0]  intf;
      logic [15:0] code;
   } err_rep_t;

endpackage

// ===== status_reporting_488.sv
// Purpose: per-interface status byte, enables, event status and last-error registers,
//          plus a shared circular fault queue
// Assumes: one request per cycle; the answer appears on the next clock edge
// Notes:   restart_i models a processor restart distinct from power-on reset
//
// Functional notes
// R1 - service request mask write keeps only bits 00111000
// R2 - MSS set when any enabled status byte bit is set
// R3 - mask read returns stored masked value; 255 reads back as 56
// R4 - event status read returns value and clears it
// R5 - event enable read returns value without change
// R6 - event enable write stored; ESB is OR of enable AND status
// R7 - restart clears both enables only when power-on clear flag is one
// R8 - power-on clear query returns stored flag unchanged
// R9 - clear-status clears errors, events, status bits except MAV, fault, supply
// R10 - reset command clears routings only, status untouched
// R11 - status byte query returns sampled value; bits 7,2,1,0 read zero
// R12 - supply fault bit tracks supply fault condition only
// R13 - MAV follows output queue non-empty
// R14 - separate register copy per interface, one shared fault queue
// R15 - MSS recomputed on every change; GPIB service request follows MSS
// R16 - query 15 pops oldest fault, zero if empty; last pop clears fault flag
// R17 - error sets its event flag and overwrites its last-error register
// R18 - last-error clears on a read once its event flag was cleared
// R19 - query codes 4, 16, 32 return query, exec, command last errors
// R20 - error event bits set when code captured, and also on a same-cycle clear-status or restart that zeroes the code
// R21 - operation complete sets OPC; query returns 1; wait does nothing
// R22 - commands are sequential; no-operation-pending always true
// R23 - event weights PON128..OPC1; URQ, DDE, RQC read zero
// R24 - MSS at weight 64; mask bit 64 ignored
// R25 - MAV at weight 16 of the status byte
// R26 - full fault queue overwrites oldest entry
// R27 - ESB weight 32, fault weight 8, supply fault position a parameter
// R28 - fault depth and error width are parameters, 16 and 16
`timescale 1ns/10ps
module status_reporting_488
   import status_pkg::*;
#(
   parameter int N_INTF      = 3,
   parameter int FAULT_DEPTH = 16, // R28
   parameter int ERR_W       = 16, // R28
   parameter int PSF_POS     = 7,
   parameter int GPIB_INTF   = 0
)(
   // clock and reset
   input  wire logic                    clk_i,
   input  wire logic                    rstn_i,
   input  wire logic                    restart_i,
   // host requests and answers
   input  wire status_pkg::host_req_t   req_i,
   output logic                         rsp_valid_o,
   output logic [15:0]                  rsp_data_o,
   output logic                         route_clear_o,
   // internal conditions
   input  wire status_pkg::err_rep_t    err_i,
   input  wire logic [N_INTF-1:0]       out_queue_busy_i,
   input  wire logic                    supply_fault_i,
   input  wire logic                    fault_push_i,
   input  wire logic [15:0]             fault_code_i,
   // per interface status view
   output logic [N_INTF-1:0][7:0]       status_byte_o,
   output logic                         gpib_srq_o
);
   import status_pkg::*;

   // pointer width of the shared fault queue
   localparam int PW = $clog2(FAULT_DEPTH);

   // ************************************************************
   // supply fault synchroniser (pin level)
   // ************************************************************
   // the pin is asynchronous: only the second flop feeds logic
   logic psf_meta;
   logic supply_fault_flag;
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         psf_meta          <= 1'b0;
         supply_fault_flag <= 1'b0;
      end
      else
      begin
         psf_meta          <= supply_fault_i;
         supply_fault_flag <= psf_meta; // R12
      end
   end

   // ************************************************************
   // shared fault queue
   // ************************************************************
   logic [15:0]   fault_mem [FAULT_DEPTH];
   logic [PW-1:0] rd_ptr;
   logic [PW-1:0] wr_ptr;
   logic [PW:0]   fault_cnt;
   logic          fault_pending_flag;
   logic          fault_pop;

   // an empty read pops nothing, so the pointers stay put
   assign fault_pending_flag = (fault_cnt != '0);
   assign fault_pop = req_i.valid && req_i.cmd == CMD_GET_Q && req_i.arg == PROP_FAULT
                      && fault_pending_flag;

   // no reset on storage: entries are only read behind the count
   always_ff @(posedge clk_i)
   begin
      if (fault_push_i)
         fault_mem[wr_ptr] <= fault_code_i;
   end

   // a push on a full queue drops the oldest entry so the newest fault is never lost
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         rd_ptr    <= '0;
         wr_ptr    <= '0;
         fault_cnt <= '0;
      end
      else
      begin
         if (fault_push_i)
            wr_ptr <= PW'((int'(wr_ptr) + 1) % FAULT_DEPTH);
         if (fault_pop || (fault_push_i && fault_cnt == (PW+1)'(FAULT_DEPTH))) // R26
            rd_ptr <= PW'((int'(rd_ptr) + 1) % FAULT_DEPTH); // R16
         if (fault_push_i && !fault_pop && fault_cnt != (PW+1)'(FAULT_DEPTH))
            fault_cnt <= fault_cnt + 1'b1;
         else if (fault_pop && !fault_push_i)
            fault_cnt <= fault_cnt - 1'b1;
      end
   end

   // ************************************************************
   // per interface register copies
   // ************************************************************
   logic [N_INTF-1:0][7:0]       svc_req_enable;
   logic [N_INTF-1:0][7:0]       event_enable;
   logic [N_INTF-1:0][7:0]       event_status;
   logic [N_INTF-1:0][ERR_W-1:0] last_query_err;
   logic [N_INTF-1:0][ERR_W-1:0] last_exec_err;
   logic [N_INTF-1:0][ERR_W-1:0] last_cmd_err;
   logic [N_INTF-1:0][2:0]       err_armed;
   logic                         poweron_status_clear;
   logic                         psc_loaded;

   // power-on clear flag is shared: it governs restart behaviour of the device
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         poweron_status_clear <= 1'b1;
      else if (req_i.valid && req_i.cmd == CMD_PSC)
         poweron_status_clear <= req_i.arg[0];
   end

   // low only in the first cycle after reset: marks power-on
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         psc_loaded <= 1'b0;
      else
         psc_loaded <= 1'b1;
   end

   // one register copy per interface; the fault queue, power-on clear flag and supply fault flag are shared
   genvar g;
   generate
      for (g = 0; g < N_INTF; g++)
      begin : gen_intf
         logic       hit;
         logic       do_cls;
         logic       do_esr_rd;
         logic       rd_lqe;
         logic       rd_lee;
         logic       rd_lce;
         logic       ev_q;
         logic       ev_e;
         logic       ev_c;
         logic       ev_opc;
         logic       pon_ev;
         logic [7:0] sb;

         assign hit       = req_i.valid && req_i.intf == 2'(g); // R14
         assign do_cls    = hit && req_i.cmd == CMD_CLS; // R9
         assign do_esr_rd = hit && req_i.cmd == CMD_ESR_Q;
         assign rd_lqe    = hit && req_i.cmd == CMD_GET_Q && req_i.arg == PROP_LQE;
         assign rd_lee    = hit && req_i.cmd == CMD_GET_Q && req_i.arg == PROP_LEE;
         assign rd_lce    = hit && req_i.cmd == CMD_GET_Q && req_i.arg == PROP_LCE;

         assign ev_q      = err_i.query && err_i.intf == 2'(g);
         assign ev_e      = err_i.exec && err_i.intf == 2'(g);
         assign ev_c      = err_i.cmd && err_i.intf == 2'(g);

         assign ev_opc    = hit && req_i.cmd == CMD_OPC; // R21
         assign pon_ev    = !psc_loaded; // R23

         // enables: restart clears them only when power-on clear is set
         always_ff @(posedge clk_i or negedge rstn_i)
         begin
            if (!rstn_i)
            begin
               svc_req_enable[g] <= RESET_BYTE;
               event_enable[g]   <= RESET_BYTE;
            end
            else if (restart_i && poweron_status_clear)
            begin
               svc_req_enable[g] <= RESET_BYTE; // R7
               event_enable[g]   <= RESET_BYTE; // R7
            end
            else
            begin
               if (hit && req_i.cmd == CMD_SRE)
                  svc_req_enable[g] <= req_i.arg & SRE_MASK; // R1 R24
               if (hit && req_i.cmd == CMD_ESE)
                  event_enable[g] <= req_i.arg; // R6
            end
         end

         // event status: new events win over a same-cycle read or clear
         // restart clears events just as a read or clear-status does
         always_ff @(posedge clk_i or negedge rstn_i)
         begin
            if (!rstn_i)
               event_status[g] <= RESET_BYTE;
            else
            begin
               logic [7:0] next_es;
               next_es = event_status[g];
               if (do_cls || do_esr_rd || restart_i)
                  next_es = RESET_BYTE; // R4 R9
               if (ev_q)
                  next_es[ES_QYE] = 1'b1; // R17 R20
               if (ev_e)
                  next_es[ES_EXE] = 1'b1; // R17 R20
               if (ev_c)
                  next_es[ES_CME] = 1'b1; // R17 R20
               if (ev_opc)
                  next_es[ES_OPC] = 1'b1; // R21
               if (pon_ev)
                  next_es[ES_PON] = 1'b1; // R23
               event_status[g] <= next_es & ES_USED; // R23
            end
         end

         // last-error registers; armed bit marks that the flag has since been cleared
         // a new capture drops the arming, so a fresh code survives every read until the next event status read
         always_ff @(posedge clk_i or negedge rstn_i)
         begin
            if (!rstn_i)
            begin
               last_query_err[g] <= '0;
               last_exec_err[g]  <= '0;
               last_cmd_err[g]   <= '0;
               err_armed[g]      <= '0;
            end
            else if (do_cls || restart_i)
            begin
               last_query_err[g] <= '0; // R9
               last_exec_err[g]  <= '0;
               last_cmd_err[g]   <= '0;
               err_armed[g]      <= '0;
            end
            else
            begin
               if (ev_q)
                  last_query_err[g] <= ERR_W'(err_i.code); // R17
               else if (rd_lqe && err_armed[g][0])
                  last_query_err[g] <= '0; // R18
               if (ev_e)
                  last_exec_err[g] <= ERR_W'(err_i.code);
               else if (rd_lee && err_armed[g][1])
                  last_exec_err[g] <= '0; // R18
               if (ev_c)
                  last_cmd_err[g] <= ERR_W'(err_i.code);
               else if (rd_lce && err_armed[g][2])
                  last_cmd_err[g] <= '0; // R18
               if (ev_q)
                  err_armed[g][0] <= 1'b0;
               else if (do_esr_rd)
                  err_armed[g][0] <= 1'b1;
               if (ev_e)
                  err_armed[g][1] <= 1'b0;
               else if (do_esr_rd)
                  err_armed[g][1] <= 1'b1;
               if (ev_c)
                  err_armed[g][2] <= 1'b0;
               else if (do_esr_rd)
                  err_armed[g][2] <= 1'b1;
            end
         end

         // status byte is live, so MSS follows every contributing change
         // MSS reads the other bits of the same byte; its own position is masked
         always_comb
         begin
            sb = 8'h00;
            sb[SB_FAULT] = fault_pending_flag; // R16 R27
            sb[SB_MAV]   = out_queue_busy_i[g]; // R13 R25
            sb[SB_ESB]   = |(event_enable[g] & event_status[g]); // R6 R27
            sb[PSF_POS]  = supply_fault_flag; // R12 R27
            sb[SB_MSS]   = |(svc_req_enable[g] & sb & SRE_MASK); // R2 R15 R24
         end

         assign status_byte_o[g] = sb;
      end
   endgenerate

   // ************************************************************
   // GPIB service request and command answers
   // ************************************************************
   // registered so the request line cannot glitch while MSS settles
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         gpib_srq_o <= 1'b0;
      else
         gpib_srq_o <= status_byte_o[GPIB_INTF][SB_MSS]; // R15
   end

   // the reset command only clears routings; nothing here is touched
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
         route_clear_o <= 1'b0;
      else
         route_clear_o <= req_i.valid && req_i.cmd == CMD_RST; // R10
   end

   // sequential processing: every query answers the next cycle, nothing pending
   // answers are registered, so a query sees the state before its own effects
   always_ff @(posedge clk_i or negedge rstn_i)
   begin
      if (!rstn_i)
      begin
         rsp_valid_o <= 1'b0;
         rsp_data_o  <= '0;
      end
      else
      begin
         logic [1:0] i;
         i = req_i.intf;
         rsp_valid_o <= 1'b0;
         if (req_i.valid)
         begin
            rsp_valid_o <= 1'b1;
            case (req_i.cmd)
               CMD_STB_Q: rsp_data_o <= {8'h00, status_byte_o[i] & 8'h78}; // R11
               CMD_SRE_Q: rsp_data_o <= {8'h00, svc_req_enable[i]}; // R3
               CMD_ESR_Q: rsp_data_o <= {8'h00, event_status[i]}; // R4
               CMD_ESE_Q: rsp_data_o <= {8'h00, event_enable[i]}; // R5
               CMD_PSC_Q: rsp_data_o <= {15'h0000, poweron_status_clear}; // R8
               CMD_OPC_Q: rsp_data_o <= 16'h0001; // R21 R22
               CMD_GET_Q:
                  // unknown property codes answer zero
                  case (req_i.arg)
                     PROP_LQE:   rsp_data_o <= 16'(last_query_err[i]); // R19
                     PROP_LEE:   rsp_data_o <= 16'(last_exec_err[i]); // R19
                     PROP_LCE:   rsp_data_o <= 16'(last_cmd_err[i]); // R19
                     PROP_FAULT: rsp_data_o <= fault_pending_flag ? fault_mem[rd_ptr]
                                                                  : 16'h0000; // R16
                     default:    rsp_data_o <= 16'h0000;
                  endcase
               // commands without an answer leave the last data standing
               default:
               begin
                  rsp_valid_o <= 1'b0; // R21
                  rsp_data_o  <= rsp_data_o;
               end
            endcase
         end
      end
   end

endmodule

// ===== status_reporting_488_monitor.sv
// Purpose: port-level checks of the status reporting register set
// Assumes: one clock, rstn_i asynchronous active low
// Notes:   sees only the top module ports; bound at the foot of this file
`timescale 1ns/10ps
module status_reporting_488_monitor
#(
   parameter int N_INTF    = 3,
   parameter int PSF_POS   = 7,
   parameter int GPIB_INTF = 0
)(
   // clock and reset
   input wire logic                      clk_i,
   input wire logic                      rstn_i,
   // host side
   input wire status_pkg::host_req_t     req_i,
   input wire logic                      rsp_valid_o,
   input wire logic [15:0]               rsp_data_o,
   input wire logic                      route_clear_o,
   // conditions and status
   input wire logic [N_INTF-1:0]         out_queue_busy_i,
   input wire logic                      supply_fault_i,
   input wire logic [N_INTF-1:0][7:0]    status_byte_o,
   input wire logic                      gpib_srq_o
);
   import status_pkg::*;
   // ************************************************************
   // helpers
   // ************************************************************
   logic              take;
   logic              is_q;
   logic [N_INTF-1:0] mav;
   // requests to a missing interface touch no register copy but still get an answer, so they are left out
   assign take = req_i.valid && (int'(req_i.intf) < N_INTF);
   assign is_q = req_i.cmd inside {CMD_STB_Q, CMD_SRE_Q, CMD_ESR_Q, CMD_ESE_Q,
                                   CMD_PSC_Q, CMD_OPC_Q, CMD_GET_Q};
   always_comb
   begin
      for (int i = 0; i < N_INTF; i++)
         mav[i] = status_byte_o[i][SB_MAV];
   end
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rstn_i);
   // ************************************************************
   // assertions
   // ************************************************************
   a_answer_when_query: assert property (
      (take || !req_i.valid) |=> rsp_valid_o == $past(take && is_q))
      else $error("answer pulse does not match the request kind");
   a_route_clear_pulse: assert property (
      take && req_i.cmd == CMD_RST |=> route_clear_o)
      else $error("reset command gave no route clear pulse");
   a_opc_query_one: assert property (
      take && req_i.cmd == CMD_OPC_Q |=> rsp_data_o == 16'h0001)
      else $error("completion query did not answer one");
   a_sre_read_masked: assert property (
      take && req_i.cmd == CMD_SRE_Q |=> (rsp_data_o & ~{8'h00, SRE_MASK}) == 16'h0000)
      else $error("service mask answer has unused bits");
   a_esr_unused_zero: assert property (
      take && req_i.cmd == CMD_ESR_Q |=> (rsp_data_o & ~{8'h00, ES_USED}) == 16'h0000)
      else $error("event answer has unused bits");
   a_stb_sampled_value: assert property (
      take && req_i.intf == 2'h0 && req_i.cmd == CMD_STB_Q
      |=> rsp_data_o == {8'h00, $past(status_byte_o[0]) & 8'h78})
      else $error("status byte answer differs from sampled byte");
   a_mav_tracks_queue: assert property (mav == out_queue_busy_i)
      else $error("message available bit differs from queue state");
   a_supply_fault_lag: assert property (
      $past(rstn_i) && $past(rstn_i, 2) |-> status_byte_o[0][PSF_POS] == $past(supply_fault_i, 2))
      else $error("supply fault bit does not follow its input");
   a_srq_follows_mss: assert property (
      $past(rstn_i) |-> gpib_srq_o == $past(status_byte_o[GPIB_INTF][SB_MSS]))
      else $error("service request does not follow summary bit");
endmodule

bind status_reporting_488 status_reporting_488_monitor #(
   .N_INTF(N_INTF), .PSF_POS(PSF_POS), .GPIB_INTF(GPIB_INTF)
) status_reporting_488_monitor_i (
   .clk_i(clk_i), .rstn_i(rstn_i), .req_i(req_i), .rsp_valid_o(rsp_valid_o),
   .rsp_data_o(rsp_data_o), .route_clear_o(route_clear_o),
   .out_queue_busy_i(out_queue_busy_i), .supply_fault_i(supply_fault_i),
   .status_byte_o(status_byte_o), .gpib_srq_o(gpib_srq_o)
);

// ===== host_model.sv
// Purpose: remote host that issues one command at a time
// Assumes: request taken on the edge after it is driven, answer read 1 ns after that same edge
// Notes:   released fields show the inverse so a stale request cannot pass
`timescale 1ns/10ps
module host_model
(
   // clock
   input  wire logic                  clk_i,
   // request out, answer in
   output status_pkg::host_req_t      req_o,
   input  wire logic                  rsp_valid_i,
   input  wire logic [15:0]           rsp_data_i
);
   import status_pkg::*;
   initial req_o = '0;
   // ************************************************************
   // one transfer; the next never starts before this answer
   // ************************************************************
   task automatic send(input logic [1:0] intf, input cmd_t cmd, input logic [7:0] arg,
                       output logic [15:0] ans, output logic got);
      @(posedge clk_i);
      #1 req_o = {1'b1, intf, cmd, arg};
      @(posedge clk_i);
      #1 req_o = {1'b0, ~intf, ~cmd, ~arg};
      got = rsp_valid_i;
      ans = rsp_data_i;
   endtask
endmodule

// ===== status_reporting_488_bench.sv
// Purpose: self-checking bench of the status reporting register set
// Assumes: host model drives requests, bench drives internal conditions
// Notes:   fault queue shortened to four entries to reach the wrap quickly
`timescale 1ns/10ps
module status_reporting_488_bench;
   import status_pkg::*;
   localparam int DEPTH = 4;
   logic             clk = 1'b0;
   logic             rstn = 1'b0;
   logic             restart = 1'b0;
   logic             supply_fault = 1'b0;
   logic             fault_push = 1'b0;
   logic [15:0]      fault_code = 16'h0000;
   logic [2:0]       busy = 3'h0;
   err_rep_t         err = '0;
   host_req_t        req;
   logic             rsp_valid, route_clear, srq, got;
   logic [15:0]      rsp_data, ans, code;
   logic [2:0][7:0]  sb;
   logic [15:0]      codes [DEPTH+2];
   logic [7:0]       v;
   int               n_errors = 0, num_checks = 0, seed = 7047;

   always #20 clk = ~clk;

   status_reporting_488 #(.FAULT_DEPTH(DEPTH)) status_reporting_488_i (
      .clk_i(clk), .rstn_i(rstn), .restart_i(restart), .req_i(req),
      .rsp_valid_o(rsp_valid), .rsp_data_o(rsp_data), .route_clear_o(route_clear),
      .err_i(err), .out_queue_busy_i(busy), .supply_fault_i(supply_fault),
      .fault_push_i(fault_push), .fault_code_i(fault_code),
      .status_byte_o(sb), .gpib_srq_o(srq));
   host_model host_model_i (.clk_i(clk), .req_o(req), .rsp_valid_i(rsp_valid),
                            .rsp_data_i(rsp_data));
   // ************************************************************
   // helpers
   // ************************************************************
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic cmd(input int i, input cmd_t c, input int a);
      host_model_i.send(2'(i), c, 8'(a), ans, got);
   endtask
   task automatic ask(input int i, input cmd_t c, input int a, input logic [15:0] exp);
      cmd(i, c, a);
      check({15'h0000, got}, 16'h0001);
      check(ans, exp);
   endtask
   task automatic raise(input logic [2:0] kind, input logic [1:0] i, input logic [15:0] c);
      @(posedge clk);
      #1 err = {kind, i, c};
      @(posedge clk);
      #1 err = '0;
   endtask
   task automatic push(input logic [15:0] c);
      @(posedge clk);
      #1 fault_code = c;
      fault_push = 1'b1;
      @(posedge clk);
      #1 fault_push = 1'b0;
   endtask
   task automatic kick();
      @(posedge clk);
      #1 restart = 1'b1;
      @(posedge clk);
      #1 restart = 1'b0;
   endtask
   // event weight of an error kind, which is also its property code
   function automatic logic [7:0] ev_bit(input int k);
      return (k == 0) ? 8'h20 : (k == 1) ? 8'h10 : 8'h04;
   endfunction
   task automatic print_verdict();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   // ************************************************************
   // scenarios
   // ************************************************************
   initial
   begin
      repeat (20) @(posedge clk);
      #1 rstn = 1'b1;
      repeat (2) @(posedge clk);
      ask(0, CMD_PSC_Q, 0, 16'h0001);
      ask(0, CMD_ESR_Q, 0, 16'h0080);
      ask(0, CMD_ESR_Q, 0, 16'h0000);
      ask(1, CMD_ESR_Q, 0, 16'h0080);
      ask(2, CMD_ESR_Q, 0, 16'h0080);
      cmd(0, CMD_SRE, 8'hff);
      ask(0, CMD_SRE_Q, 0, 16'h0038);
      repeat (6)
      begin
         v = 8'($random(seed));
         cmd(0, CMD_SRE, v);
         ask(0, CMD_SRE_Q, 0, {8'h00, v & SRE_MASK});
         cmd(0, CMD_ESE, v);
         ask(0, CMD_ESE_Q, 0, {8'h00, v});
         ask(0, CMD_ESE_Q, 0, {8'h00, v});
      end
      cmd(0, CMD_ESE, 8'h01);
      cmd(0, CMD_SRE, 8'h20);
      cmd(0, CMD_OPC, 0);
      check(16'(sb[0] & 8'h60), 16'h0060);
      @(posedge clk);
      #1 check({15'h0000, srq}, 16'h0001);
      check(16'(sb[1] & 8'h60), 16'h0000);
      cmd(0, CMD_ESE, 8'h00);
      check(16'(sb[0] & 8'h60), 16'h0000);
      ask(0, CMD_ESR_Q, 0, 16'h0001);
      cmd(1, CMD_WAI, 0);
      check({15'h0000, got}, 16'h0000);
      cmd(1, CMD_SRE, 8'h10);
      busy = 3'b010;
      ask(1, CMD_STB_Q, 0, 16'h0050);
      busy = 3'b000;
      ask(1, CMD_STB_Q, 0, 16'h0000);
      for (int k = 0; k < 3; k++)
      begin
         code = {8'h00, 8'($random(seed))} + 16'h0001;
         raise(3'b001 << k, 2'h2, ~code);
         raise(3'b001 << k, 2'h2, code);
         ask(2, CMD_GET_Q, ev_bit(k), code);
         ask(2, CMD_GET_Q, ev_bit(k), code);
         ask(2, CMD_ESR_Q, 0, 16'(ev_bit(k)));
         ask(2, CMD_GET_Q, ev_bit(k), code);
         ask(2, CMD_GET_Q, ev_bit(k), 16'h0000);
      end
      raise(3'b001, 2'h0, 16'h0042);
      busy = 3'b001;
      push(16'h0007);
      cmd(1, CMD_OPC, 0);
      cmd(0, CMD_CLS, 0);
      check(16'(sb[0] & 8'h18), 16'h0018);
      ask(0, CMD_ESR_Q, 0, 16'h0000);
      ask(0, CMD_GET_Q, 8'h20, 16'h0000);
      ask(1, CMD_ESR_Q, 0, 16'h0001);
      busy = 3'b000;
      ask(0, CMD_GET_Q, 8'h0f, 16'h0007);
      check(16'(sb[0] & 8'h08), 16'h0000);
      for (int k = 0; k < DEPTH + 2; k++)
      begin
         codes[k] = 16'($random(seed)) | 16'h0001;
         push(codes[k]);
      end
      for (int k = 2; k < DEPTH + 2; k++)
         ask(1, CMD_GET_Q, 8'h0f, codes[k]);
      ask(0, CMD_GET_Q, 8'h0f, 16'h0000);
      cmd(0, CMD_SRE, 8'h08);
      cmd(0, CMD_ESE, 8'h81);
      cmd(0, CMD_RST, 0);
      check({15'h0000, route_clear}, 16'h0001);
      ask(0, CMD_SRE_Q, 0, 16'h0008);
      cmd(0, CMD_PSC, 8'h00);
      ask(0, CMD_PSC_Q, 0, 16'h0000);
      kick();
      ask(0, CMD_ESE_Q, 0, 16'h0081);
      cmd(0, CMD_PSC, 8'h01);
      kick();
      ask(0, CMD_SRE_Q, 0, 16'h0000);
      ask(0, CMD_ESE_Q, 0, 16'h0000);
      supply_fault = 1'b1;
      repeat (3) @(posedge clk);
      #1 check(16'(sb[0][7]), 16'h0001);
      ask(0, CMD_STB_Q, 0, 16'h0000);
      supply_fault = 1'b0;
      repeat (3) @(posedge clk);
      #1 check(16'(sb[0][7]), 16'h0000);
      print_verdict();
   end
   // the run needs well under a thousand cycles; five thousand means a hang
   initial
   begin
      #200000;
      n_errors++;
      print_verdict();
   end
endmodule
